// ### logic/dcb_dual_counter.sv
// Dual 16-bit counter with capture registers, byte readout bus and AXI4-Lite view.
`timescale 1ns/1ps
`include "dcb_consts.svh"

module dcb_dual_counter (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                count_clk_first,
  input  wire logic                count_clk_second,
  input  wire logic                capture_clk,
  input  wire logic                second_count_enable_n,
  input  wire logic                counter_clear_n,
  input  wire logic                sel_a_low_byte_n,
  input  wire logic                sel_a_high_byte_n,
  input  wire logic                sel_b_low_byte_n,
  input  wire logic                sel_b_high_byte_n,
  output logic                     first_carry_out_n,
  output dcb_pkg::dcb_byte_t       byte_out_bus,
  output logic                     byte_out_bus_oe,
  input  wire dcb_pkg::dcb_addr_t  s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire dcb_pkg::dcb_word_t  s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire dcb_pkg::dcb_addr_t  s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output dcb_pkg::dcb_word_t       s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import dcb_pkg::*;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [`DCB_SYNC_W-1:0] pins_async;
  logic [`DCB_SYNC_W-1:0] pins_sync;
  logic [`DCB_SYNC_W-1:0] pins_rise;
  logic                   rise_a;
  logic                   rise_b;
  logic                   rise_cap;
  logic                   enable_b_n;
  logic                   clear_n;
  logic [3:0]             sel_n;

  // Every pin is treated as asynchronous; active-low pins reset to their idle high level.
  assign pins_async = {sel_b_high_byte_n, sel_b_low_byte_n, sel_a_high_byte_n, sel_a_low_byte_n,
                       counter_clear_n, second_count_enable_n, capture_clk, count_clk_second,
                       count_clk_first};

  dcb_sync_edge #(.W (`DCB_SYNC_W), .RESET_VAL (`DCB_SYNC_RST)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pins_async),
    .sync_out (pins_sync),
    .rise_out (pins_rise)
  );

  // Count and capture clocks use only their detected rising edges.
  assign rise_a     = pins_rise[0];
  assign rise_b     = pins_rise[1];
  assign rise_cap   = pins_rise[2];
  assign enable_b_n = pins_sync[3];
  assign clear_n    = pins_sync[4];
  assign sel_n      = pins_sync[8:5];

  // ****************************************************************
  // Register state
  // ****************************************************************
  dcb_count_t    count_a;
  dcb_count_t    count_b;
  dcb_count_t    hold_a;
  dcb_count_t    hold_b;
  logic          soft_clear;
  dcb_count_t    next_count_a;
  dcb_count_t    next_count_b;
  dcb_count_t    next_hold_a;
  dcb_count_t    next_hold_b;
  logic          next_soft_clear;
  logic          next_carry_n;
  logic          clearing;
  logic          capture_now;
  dcb_wr_state_t wr_state;
  dcb_wr_state_t next_wr_state;
  dcb_addr_t     wr_addr_q;
  dcb_word_t     wr_data_q;
  logic [3:0]    wr_strb_q;
  dcb_addr_t     next_wr_addr_q;
  dcb_word_t     next_wr_data_q;
  logic [3:0]    next_wr_strb_q;
  logic          aw_hs;
  logic          w_hs;
  logic          do_write;
  dcb_addr_t     wr_addr;
  dcb_word_t     wr_data;
  logic [3:0]    wr_strb;
  logic          next_awready;
  logic          next_wready;
  logic          next_bvalid;
  logic [1:0]    next_bresp;
  logic          ar_hs;
  logic          next_arready;
  logic          next_rvalid;
  dcb_word_t     next_rdata;
  logic [1:0]    next_rresp;
  dcb_byte_t     next_byte;
  logic          next_byte_oe;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs  = s_axi_wvalid & s_axi_wready;
  // Address and data may arrive in either order; whichever comes first is parked.
  always_comb begin
    next_wr_state  = wr_state;
    next_wr_addr_q = wr_addr_q;
    next_wr_data_q = wr_data_q;
    next_wr_strb_q = wr_strb_q;
    do_write       = 1'b0;
    wr_addr        = (wr_state == DCB_WR_HAVE_ADDR) ? wr_addr_q : s_axi_awaddr;
    wr_data        = (wr_state == DCB_WR_HAVE_DATA) ? wr_data_q : s_axi_wdata;
    wr_strb        = (wr_state == DCB_WR_HAVE_DATA) ? wr_strb_q : s_axi_wstrb;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    case (wr_state)
      DCB_WR_IDLE: begin
        if (aw_hs && w_hs) begin
          do_write      = 1'b1;
          next_wr_state = DCB_WR_RESP;
        end else if (aw_hs) begin
          next_wr_addr_q = s_axi_awaddr;
          next_wr_state  = DCB_WR_HAVE_ADDR;
        end else if (w_hs) begin
          next_wr_data_q = s_axi_wdata;
          next_wr_strb_q = s_axi_wstrb;
          next_wr_state  = DCB_WR_HAVE_DATA;
        end
      end
      DCB_WR_HAVE_ADDR: begin
        if (w_hs) begin
          do_write      = 1'b1;
          next_wr_state = DCB_WR_RESP;
        end
      end
      DCB_WR_HAVE_DATA: begin
        if (aw_hs) begin
          do_write      = 1'b1;
          next_wr_state = DCB_WR_RESP;
        end
      end
      DCB_WR_RESP: begin
        if (s_axi_bready) begin
          next_bvalid   = 1'b0;
          next_wr_state = DCB_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = DCB_WR_IDLE;
      end
    endcase
    // Only the control word is writable; anything else answers with a slave error.
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = (wr_addr == `DCB_OFF_CTRL) ? `DCB_RESP_OKAY : `DCB_RESP_SLVERR;
    end
    next_awready = (next_wr_state == DCB_WR_IDLE) || (next_wr_state == DCB_WR_HAVE_DATA);
    next_wready  = (next_wr_state == DCB_WR_IDLE) || (next_wr_state == DCB_WR_HAVE_ADDR);
  end

  // ****************************************************************
  // Counters and capture registers
  // ****************************************************************
  // The clear pin and the soft clear bit both hold the counters at zero.
  always_comb begin
    next_soft_clear = soft_clear;
    capture_now     = rise_cap;
    if (do_write && (wr_addr == `DCB_OFF_CTRL) && wr_strb[0]) begin
      next_soft_clear = wr_data[`DCB_CTRL_SOFT_CLR];
      capture_now     = rise_cap | wr_data[`DCB_CTRL_CAPTURE];
    end
    clearing = ~clear_n | soft_clear;
    if (clearing) begin
      next_count_a = `DCB_CNT_RST;
      next_count_b = `DCB_CNT_RST;
    end else begin
      next_count_a = rise_a ? count_a + `DCB_CNT_ONE : count_a;
      next_count_b = (rise_b && !enable_b_n) ? count_b + `DCB_CNT_ONE : count_b;
    end
    // A capture on the same cycle as a count edge takes the value before the step.
    next_hold_a  = capture_now ? count_a : hold_a;
    next_hold_b  = capture_now ? count_b : hold_b;
    // The carry is computed from the next count so it lines up with the counter flop.
    next_carry_n = ~(next_count_a == `DCB_CNT_TERMINAL);
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  // One read at a time: the address is refused while the answer waits.
  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (ar_hs) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = `DCB_RESP_OKAY;
      next_rdata   = `DCB_WORD_RST;
      case (s_axi_araddr)
        `DCB_OFF_CTRL: begin
          next_rdata[`DCB_CTRL_SOFT_CLR] = soft_clear;
        end
        `DCB_OFF_LIVE_A: begin
          next_rdata[15:0] = count_a;
        end
        `DCB_OFF_LIVE_B: begin
          next_rdata[15:0] = count_b;
        end
        `DCB_OFF_HOLD: begin
          next_rdata = {hold_b, hold_a};
        end
        `DCB_OFF_STATUS: begin
          next_rdata[`DCB_STAT_CLEARING] = clearing;
          next_rdata[`DCB_STAT_CARRY_N]  = first_carry_out_n;
        end
        default: begin
          next_rresp = `DCB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  // ****************************************************************
  // Byte readout bus
  // ****************************************************************
  // Exactly one low select picks a byte; several low drive a don't-care zero byte.
  always_comb begin
    next_byte_oe = 1'b1;
    next_byte    = `DCB_BYTE_RST;
    case (sel_n)
      4'hE: begin
        next_byte = hold_a[7:0];
      end
      4'hD: begin
        next_byte = hold_a[15:8];
      end
      4'hB: begin
        next_byte = hold_b[7:0];
      end
      4'h7: begin
        next_byte = hold_b[15:8];
      end
      4'hF: begin
        next_byte_oe = 1'b0;
      end
      default: begin
        next_byte = `DCB_BYTE_RST;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  // All state except the pin synchroniser's, including every output, is registered here under the bus reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_a           <= `DCB_CNT_RST;
      count_b           <= `DCB_CNT_RST;
      hold_a            <= `DCB_CNT_RST;
      hold_b            <= `DCB_CNT_RST;
      soft_clear        <= 1'b0;
      first_carry_out_n <= 1'b1;
      byte_out_bus      <= `DCB_BYTE_RST;
      byte_out_bus_oe   <= 1'b0;
      wr_state          <= DCB_WR_IDLE;
      wr_addr_q         <= '0;
      wr_data_q         <= `DCB_WORD_RST;
      wr_strb_q         <= 4'h0;
      s_axi_awready     <= 1'b1;
      s_axi_wready      <= 1'b1;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `DCB_RESP_OKAY;
      s_axi_arready     <= 1'b1;
      s_axi_rvalid      <= 1'b0;
      s_axi_rdata       <= `DCB_WORD_RST;
      s_axi_rresp       <= `DCB_RESP_OKAY;
    end else begin
      count_a           <= next_count_a;
      count_b           <= next_count_b;
      hold_a            <= next_hold_a;
      hold_b            <= next_hold_b;
      soft_clear        <= next_soft_clear;
      first_carry_out_n <= next_carry_n;
      byte_out_bus      <= next_byte;
      byte_out_bus_oe   <= next_byte_oe;
      wr_state          <= next_wr_state;
      wr_addr_q         <= next_wr_addr_q;
      wr_data_q         <= next_wr_data_q;
      wr_strb_q         <= next_wr_strb_q;
      s_axi_awready     <= next_awready;
      s_axi_wready      <= next_wready;
      s_axi_bvalid      <= next_bvalid;
      s_axi_bresp       <= next_bresp;
      s_axi_arready     <= next_arready;
      s_axi_rvalid      <= next_rvalid;
      s_axi_rdata       <= next_rdata;
      s_axi_rresp       <= next_rresp;
    end
  end

endmodule

// ### logic/dcb_consts.svh
// Constants of the dual counter with byte readout: offsets, fields, reset values.
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH

// ****************************************************************
// Register bus geometry
// ****************************************************************
`define DCB_ADDR_W        8
`define DCB_DATA_W        32
`define DCB_CNT_W         16
`define DCB_BYTE_W        8

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define DCB_OFF_CTRL      8'h00
`define DCB_OFF_LIVE_A    8'h04
`define DCB_OFF_LIVE_B    8'h08
`define DCB_OFF_HOLD      8'h0C
`define DCB_OFF_STATUS    8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define DCB_CTRL_SOFT_CLR 0
`define DCB_CTRL_CAPTURE  1
`define DCB_STAT_CLEARING 0
`define DCB_STAT_CARRY_N  1

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define DCB_CNT_RST       16'h0000
`define DCB_CNT_TERMINAL  16'hFFFF
`define DCB_CNT_ONE       16'h0001
`define DCB_BYTE_RST      8'h00
`define DCB_WORD_RST      32'h0000_0000
`define DCB_RESP_OKAY     2'h0
`define DCB_RESP_SLVERR   2'h2
`define DCB_SYNC_W        9
`define DCB_SYNC_RST      9'h1F8

`endif

// ### logic/dcb_pkg.sv
// Types shared by the dual counter with byte readout.
package dcb_pkg;

  typedef logic [15:0] dcb_count_t;
  typedef logic [31:0] dcb_word_t;
  typedef logic [7:0]  dcb_addr_t;
  typedef logic [7:0]  dcb_byte_t;

  // Write channel progress of the register slave.
  typedef enum logic [1:0] {
    DCB_WR_IDLE      = 2'b00,
    DCB_WR_HAVE_ADDR = 2'b01,
    DCB_WR_HAVE_DATA = 2'b10,
    DCB_WR_RESP      = 2'b11
  } dcb_wr_state_t;

endpackage

// ### logic/dcb_sync_edge.sv
// Two-flop synchroniser with rising-edge detect for a group of pin inputs.
`timescale 1ns/1ps
module dcb_sync_edge #(
  parameter int          W         = 9,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  output logic      [W-1:0] rise_out
);

  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stage2;
  logic [W-1:0] next_stage3;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************

  // The first stage feeds only the second; the edge detector looks at stages two and three.
  always_comb begin
    next_meta   = async_in;
    next_stage2 = meta;
    next_stage3 = stage2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta   <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      meta   <= next_meta;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  // Only a low-to-high change counts as an edge, so falling edges are ignored.
  assign sync_out = stage2;
  assign rise_out = stage2 & ~stage3;

endmodule

// ### sim/dcb_checker.sv
// Concurrent checks on the pins and register port of the dual counter.
`timescale 1ns/1ps
module dcb_checker (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               count_clk_first,
  input wire logic               counter_clear_n,
  input wire logic               sel_a_low_byte_n,
  input wire logic               sel_a_high_byte_n,
  input wire logic               sel_b_low_byte_n,
  input wire logic               sel_b_high_byte_n,
  input wire logic               first_carry_out_n,
  input wire logic               byte_out_bus_oe,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire dcb_pkg::dcb_addr_t s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire dcb_pkg::dcb_word_t s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready
);
  import dcb_pkg::*;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic all_high;
  logic one_low;
  // Select decode; five cycles cover two sync flops plus the output register.
  assign all_high = sel_a_low_byte_n & sel_a_high_byte_n & sel_b_low_byte_n & sel_b_high_byte_n;
  assign one_low  = ($countones({sel_a_low_byte_n, sel_a_high_byte_n, sel_b_low_byte_n, sel_b_high_byte_n}) == 3);
  bus_release_a: assert property (all_high [*5] |-> !byte_out_bus_oe)
    else $error("Byte bus driven with every select high.");
  bus_drive_a: assert property (one_low [*5] |-> byte_out_bus_oe)
    else $error("Byte bus not driven with one select low.");
  clear_carry_a: assert property (!counter_clear_n [*5] |-> first_carry_out_n)
    else $error("Carry low while counters are held clear.");
  // Without a count edge or a register write the carry must not move.
  carry_hold_a: assert property ((counter_clear_n && !s_axi_wvalid && $stable(count_clk_first)) [*6]
    |-> $stable(first_carry_out_n))
    else $error("Carry changed with no count edge.");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("Write response late.");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before accept.");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late.");
  rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped read not refused.");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data changed before accept.");
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(byte_out_bus_oe));
endmodule

bind dcb_dual_counter dcb_checker i_chk (.aclk, .aresetn, .count_clk_first, .counter_clear_n,
  .sel_a_low_byte_n, .sel_a_high_byte_n, .sel_b_low_byte_n, .sel_b_high_byte_n, .first_carry_out_n,
  .byte_out_bus_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### sim/dcb_byte_reader.sv
// Behavioural reader that fetches one byte at a time from the three-state bus.
`timescale 1ns/1ps
module dcb_byte_reader (
  input  wire logic               aclk,
  input  wire dcb_pkg::dcb_byte_t byte_out_bus,
  input  wire logic               byte_out_bus_oe,
  output logic                    sel_a_low_byte_n,
  output logic                    sel_a_high_byte_n,
  output logic                    sel_b_low_byte_n,
  output logic                    sel_b_high_byte_n
);
  import dcb_pkg::*;
  logic [3:0] sel_n = 4'hF;
  wire  [7:0] bus_wire;
  // The data lines have no pull, so a released bus floats.
  assign bus_wire = byte_out_bus_oe ? byte_out_bus : 8'hZZ;
  assign {sel_b_high_byte_n, sel_b_low_byte_n, sel_a_high_byte_n, sel_a_low_byte_n} = sel_n;
  // Index 0 and 1 pick the low and high byte of A, 2 and 3 those of B.
  task read_byte(input int idx, output logic [7:0] val);
    @(posedge aclk);
    sel_n <= ~(4'h1 << idx);
    repeat (6) @(posedge aclk);
    val = bus_wire;
    sel_n <= 4'hF;
    // An idle gap before the next select keeps the bus turnaround clean.
    repeat (6) @(posedge aclk);
  endtask
endmodule

// ### sim/test_dcb_dual_counter.sv
// Self-checking bench for the dual counter with byte readout.
`timescale 1ns/1ps
`include "dcb_consts.svh"
module test_dcb_dual_counter;
  import dcb_pkg::*;
  logic      aclk = 1'b0, aresetn = 1'b0, en_n = 1'b1, clr_n = 1'b1;
  logic      [2:0] pclk = 3'h0;
  logic      s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic      s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic      [3:0] s_axi_wstrb = 4'hF;
  logic      [1:0] s_axi_bresp, s_axi_rresp;
  dcb_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  dcb_word_t s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  dcb_byte_t byte_out_bus;
  logic      first_carry_out_n, byte_out_bus_oe;
  wire       sel_a_low_byte_n, sel_a_high_byte_n, sel_b_low_byte_n, sel_b_high_byte_n;
  int        n_fail = 0, samples_checked = 0, cnt_a = 0, cnt_b = 0, hold_a = 0, hold_b = 0;
  logic      [31:0] seed = 32'h184D;

  dcb_dual_counter i_dut (.aclk, .aresetn, .count_clk_first(pclk[0]), .count_clk_second(pclk[1]),
    .capture_clk(pclk[2]), .second_count_enable_n(en_n), .counter_clear_n(clr_n), .sel_a_low_byte_n,
    .sel_a_high_byte_n, .sel_b_low_byte_n, .sel_b_high_byte_n, .first_carry_out_n, .byte_out_bus,
    .byte_out_bus_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dcb_byte_reader i_reader (.aclk, .byte_out_bus, .byte_out_bus_oe, .sel_a_low_byte_n,
    .sel_a_high_byte_n, .sel_b_low_byte_n, .sel_b_high_byte_n);

  // 25 MHz clock.
  always #20 aclk = ~aclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Ready is raised one cycle late so that the slave must hold its answer.
  task axi_wr(input dcb_addr_t a, input dcb_word_t d, output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    while (!(aw_ok && w_ok) && n < 40) begin
      @(posedge aclk);
      n++;
      if (!aw_ok && s_axi_awready) begin aw_ok = 1; s_axi_awvalid <= 1'b0; end
      if (!w_ok && s_axi_wready) begin w_ok = 1; s_axi_wvalid <= 1'b0; end
    end
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin n_fail++; finish_test(); end
  endtask

  task axi_rd(input dcb_addr_t a, output dcb_word_t d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 40);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 80);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin n_fail++; finish_test(); end
  endtask

  task chk_rd(input dcb_addr_t a, input logic [31:0] exp, input logic [1:0] er);
    dcb_word_t d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, exp);
    check(r, er);
  endtask

  // Pin pulse, three cycles high and low; 0 A, 1 B, 2 capture, 3 both count clocks.
  task pin_pulse(input int which);
    @(posedge aclk);
    if (which == 3) pclk[1:0] <= 2'b11;
    else pclk[which] <= 1'b1;
    repeat (3) @(posedge aclk);
    pclk <= 3'h0;
    repeat (3) @(posedge aclk);
    if (which == 2) begin hold_a = cnt_a; hold_b = cnt_b; end
    else if (clr_n) begin
      if (which != 1) cnt_a = (cnt_a + 1) % 65536;
      if (which != 0 && !en_n) cnt_b = (cnt_b + 1) % 65536;
    end
  endtask

  // Every view of the counts against the model, falling edges already passed.
  task chk_all;
    logic [7:0] b;
    chk_rd(`DCB_OFF_LIVE_A, cnt_a, `DCB_RESP_OKAY);
    chk_rd(`DCB_OFF_LIVE_B, cnt_b, `DCB_RESP_OKAY);
    chk_rd(`DCB_OFF_HOLD, {hold_b[15:0], hold_a[15:0]}, `DCB_RESP_OKAY);
    chk_rd(`DCB_OFF_STATUS, {30'h0, 1'(cnt_a != 65535), !clr_n}, `DCB_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      i_reader.read_byte(i, b);
      check(b, (((i > 1) ? hold_b : hold_a) >> (8 * (i % 2))) & 255);
    end
    check(i_reader.bus_wire, 8'hZZ);
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  // Main sequence.
  initial begin
    logic [1:0] r;
    int k;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_all();
    chk_rd(8'h14, 32'h0000_0000, `DCB_RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      k = (seed[5:4] == 2'h2) ? 3 : seed[5:4];
      // With the count clocks tied, the second counter's enable is loaded once from the carry output before the pulses.
      en_n <= (k == 3) ? first_carry_out_n : seed[0];
      repeat (3) @(posedge aclk);
      for (int j = 0; j <= seed[3:1]; j++) pin_pulse(k);
      pin_pulse(2);
      chk_all();
    end
    // Clear pin: counts held at zero, then resume from zero.
    clr_n <= 1'b0;
    repeat (4) @(posedge aclk);
    cnt_a = 0;
    cnt_b = 0;
    pin_pulse(3);
    pin_pulse(2);
    chk_all();
    clr_n <= 1'b1;
    repeat (4) @(posedge aclk);
    pin_pulse(0);
    pin_pulse(2);
    chk_all();
    // A read-only place refuses writes; soft clear and capture command.
    seed = lfsr_next(seed);
    axi_wr(`DCB_OFF_LIVE_A, seed, r);
    check(r, `DCB_RESP_SLVERR);
    pin_pulse(0);
    axi_wr(`DCB_OFF_CTRL, 32'h0000_0001, r);
    check(r, `DCB_RESP_OKAY);
    cnt_a = 0;
    cnt_b = 0;
    chk_rd(`DCB_OFF_CTRL, 32'h0000_0001, `DCB_RESP_OKAY);
    chk_rd(`DCB_OFF_STATUS, 32'h0000_0003, `DCB_RESP_OKAY);
    axi_wr(`DCB_OFF_CTRL, 32'h0000_0000, r);
    pin_pulse(0);
    axi_wr(`DCB_OFF_CTRL, 32'h0000_0002, r);
    hold_a = cnt_a;
    hold_b = cnt_b;
    chk_all();
    // A second reset in mid-run empties counters and holds.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    {cnt_a, cnt_b, hold_a, hold_b} = '0;
    chk_all();
    finish_test();
  end
endmodule
